// file: pif_params.svh
// Constants for the peripheral interrupt flag block
`ifndef PIF_PARAMS_SVH
`define PIF_PARAMS_SVH

// Register byte offsets on the APB bus
`define PIF_OFF_FLAGS 12'h00C
`define PIF_OFF_MASK 12'h010
`define PIF_OFF_IRQ 12'h014

// Flag bit positions
`define PIF_BIT_TIMER_ONE_COUNT 0
`define PIF_BIT_TIMER_TWO_COUNT 1
`define PIF_BIT_CCP 2
`define PIF_BIT_SSP 3
`define PIF_BIT_TXE 4
`define PIF_BIT_RXF 5

// Widths and reset values
`define PIF_FLAG_W 8
`define PIF_ADDR_W 12
`define PIF_FLAGS_RST 8'h00
`define PIF_MASK_RST 8'h00
`define PIF_CCP_MODE_W 2

`endif

// file: pif_pkg.sv
// Types for the peripheral interrupt flag block
package pif_pkg;
    // Capture/compare unit operating mode
    typedef enum logic [1:0] {
        PIF_CCP_OFF = 2'b00,
        PIF_CCP_CAPTURE = 2'b01,
        PIF_CCP_COMPARE = 2'b10,
        PIF_CCP_PWM = 2'b11
    } pif_ccp_mode_t;
endpackage

// file: pif_sync.sv
// Two flip-flop level synchroniser for an input from outside the clock domain
`timescale 1ns/1ps
module pif_sync (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic asyncIn,
    output logic syncOut
);
    logic stageOne;

    // First stage feeds only the second
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stageOne <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            stageOne <= asyncIn;
            syncOut <= stageOne;
        end
    end
endmodule

// file: pif_sticky.sv
// One sticky flag bit: hardware set wins over software clear
`timescale 1ns/1ps
module pif_sticky (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic setEvent,
    input wire logic swWrite,
    input wire logic swValue,
    output logic flag
);
    // Set has priority so an event in the clearing cycle is kept
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            flag <= 1'b0;
        end else if (setEvent) begin
            flag <= 1'b1;
        end else if (swWrite) begin
            flag <= swValue;
        end
    end
endmodule

// file: pif_flags.sv
// Peripheral interrupt flag register with APB slave, mask and interrupt output
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "pif_params.svh"

// Overview of operation
// - Each flag sets on its event regardless of any enable bits.
// - Without serial unit, bits 5 and 4 read zero and ignore writes.
// - Sync serial flag sets on transfer completion, holds until software clears.
// - In capture mode the capcomp flag sets on a timer one capture.
// - In compare mode it sets on compare match; unused in PWM mode.
// - Timer two flag sets on count matching period, held until cleared.
// - Timer one flag sets on overflow, held until software writes zero.
// - Receive flag is read-only, high while receive buffer holds data.
// - Transmit flag is read-only, high while transmit buffer is empty.
// - All implemented flag bits reset to zero.
module pif_flags #(
    parameter bit HAS_SERIAL = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic syncSerialDone,
    input wire logic capcompEvent,
    input wire pif_pkg::pif_ccp_mode_t capcompMode,
    input wire logic timerTwoMatch,
    input wire logic timerOneOverflow,
    input wire logic serialRxFullIn,
    input wire logic serialTxEmptyIn,
    output logic irq
);
    logic [`PIF_FLAG_W-1:0] peripheralFlagReg;
    logic [`PIF_FLAG_W-1:0] irqMask;
    logic wrStrobe;
    logic rdStrobe;
    logic [`PIF_ADDR_W-1:0] regAddr;
    logic addrHit;
    logic flagWrite;
    logic ccpSet;
    logic rxFullSync;
    logic txEmptySync;
    logic [`PIF_FLAG_W-1:0] pending;

    // Only two bits (5 and 4) are variant-dependent, so a parameter check is enough
    initial begin
        if (`PIF_FLAG_W != 8) begin
            $error("flag register must be eight bits wide");
        end
    end

    // APB decode: answer in the access phase with no wait states
    assign regAddr = paddr[`PIF_ADDR_W-1:0];
    assign wrStrobe = psel && penable && pwrite;
    assign rdStrobe = psel && penable && !pwrite;
    assign addrHit = (regAddr == `PIF_OFF_FLAGS) || (regAddr == `PIF_OFF_MASK)
        || (regAddr == `PIF_OFF_IRQ);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addrHit;
    assign flagWrite = wrStrobe && (regAddr == `PIF_OFF_FLAGS);

    // Capture or compare event only counts in capture and compare modes
    assign ccpSet = capcompEvent && ((capcompMode == pif_pkg::PIF_CCP_CAPTURE)
        || (capcompMode == pif_pkg::PIF_CCP_COMPARE));

    // Software-clearable sticky flags, set irrespective of mask
    pif_sticky u_timer_one_count (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .setEvent(timerOneOverflow),
        .swWrite(flagWrite),
        .swValue(pwdata[`PIF_BIT_TIMER_ONE_COUNT]),
        .flag(peripheralFlagReg[`PIF_BIT_TIMER_ONE_COUNT])
    );
    pif_sticky u_timer_two_count (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .setEvent(timerTwoMatch),
        .swWrite(flagWrite),
        .swValue(pwdata[`PIF_BIT_TIMER_TWO_COUNT]),
        .flag(peripheralFlagReg[`PIF_BIT_TIMER_TWO_COUNT])
    );
    pif_sticky u_ccp (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .setEvent(ccpSet),
        .swWrite(flagWrite),
        .swValue(pwdata[`PIF_BIT_CCP]),
        .flag(peripheralFlagReg[`PIF_BIT_CCP])
    );
    pif_sticky u_ssp (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .setEvent(syncSerialDone),
        .swWrite(flagWrite),
        .swValue(pwdata[`PIF_BIT_SSP]),
        .flag(peripheralFlagReg[`PIF_BIT_SSP])
    );

    // Buffer status levels come from the serial unit's own logic domain pins
    pif_sync u_rxsync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .asyncIn(serialRxFullIn),
        .syncOut(rxFullSync)
    );
    pif_sync u_txsync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .asyncIn(serialTxEmptyIn),
        .syncOut(txEmptySync)
    );

    // Read-only buffer flags: they mirror buffer state, writes do nothing
    assign peripheralFlagReg[`PIF_BIT_RXF] = HAS_SERIAL && rxFullSync;
    assign peripheralFlagReg[`PIF_BIT_TXE] = HAS_SERIAL && txEmptySync;
    // Reserved top bits hold zero; writes there are dropped
    assign peripheralFlagReg[7:6] = 2'h0;

    // Mask register, same layout as the flags
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irqMask <= `PIF_MASK_RST;
        end else if (wrStrobe && (regAddr == `PIF_OFF_MASK)) begin
            irqMask <= pwdata[`PIF_FLAG_W-1:0] & 8'h3F;
        end
    end

    // Level interrupt while any unmasked flag is set
    assign pending = peripheralFlagReg & irqMask;
    assign irq = |pending;

    // Read data is not registered at the access edge; one cycle late is avoided
    // by making it combinational on the current state instead
    always_comb begin
        prdata = 32'h0000_0000;
        if (rdStrobe) begin
            unique case (regAddr)
                `PIF_OFF_FLAGS: prdata = {24'h00_0000, peripheralFlagReg};
                `PIF_OFF_MASK: prdata = {24'h00_0000, irqMask};
                `PIF_OFF_IRQ: prdata = {24'h00_0000, pending};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // Checks
    reset_zero_a: assert property (@(posedge sys_clk)
        $rose(rstn) |-> peripheralFlagReg[3:0] == 4'h0)
        else $error("flags not zero after reset");
    timer_one_count_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        timerOneOverflow |=> peripheralFlagReg[0])
        else $error("timer one flag not set");
    timer_two_count_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        timerTwoMatch |=> peripheralFlagReg[1])
        else $error("timer two flag not set");
    ssp_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        syncSerialDone |=> peripheralFlagReg[3])
        else $error("sync serial flag not set");
    ccp_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (capcompEvent && capcompMode == pif_pkg::PIF_CCP_CAPTURE) |=> peripheralFlagReg[2])
        else $error("capture flag not set");
    ccp_cmp_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (capcompEvent && capcompMode == pif_pkg::PIF_CCP_COMPARE) |=> peripheralFlagReg[2])
        else $error("compare flag not set");
    ccp_pwm_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!peripheralFlagReg[2] && !flagWrite && capcompMode == pif_pkg::PIF_CCP_PWM)
        |=> !peripheralFlagReg[2])
        else $error("capcomp flag set in PWM mode");
    flag_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (peripheralFlagReg[0] && !flagWrite) |=> peripheralFlagReg[0])
        else $error("timer one flag dropped without a write");
    set_wins_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (flagWrite && !pwdata[3] && syncSerialDone) |=> peripheralFlagReg[3])
        else $error("clear beat set");
    rx_mirror_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        peripheralFlagReg[5] == (HAS_SERIAL && $past(serialRxFullIn, 2)))
        else $error("receive flag wrong");
    tx_mirror_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        peripheralFlagReg[4] == (HAS_SERIAL && $past(serialTxEmptyIn, 2)))
        else $error("transmit flag wrong");
    irq_level_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        irq == |(peripheralFlagReg & irqMask))
        else $error("interrupt output wrong");

    timer_one_count_cov_c: cover property (@(posedge sys_clk) disable iff (!rstn)
        timerOneOverflow ##1 flagWrite ##1 !peripheralFlagReg[0]);
    irq_cov_c: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(irq));
    race_cov_c: cover property (@(posedge sys_clk) disable iff (!rstn)
        flagWrite && syncSerialDone);
endmodule

// file: test_peripheral_interrupt_flags.sv
// Self-checking bench for the peripheral interrupt flag block
`timescale 1ns/1ps
`include "pif_params.svh"
module test_peripheral_interrupt_flags;
    logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic rxFull, txEmpty;
    logic [3:0] ev;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [31:0] prdataBasic, rdBasic;
    pif_pkg::pif_ccp_mode_t ccpMode;
    int mismatches, nChecks;

    pif_flags #(.HAS_SERIAL(1'b1)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .syncSerialDone(ev[3]),
        .capcompEvent(ev[2]), .capcompMode(ccpMode), .timerTwoMatch(ev[1]),
        .timerOneOverflow(ev[0]), .serialRxFullIn(rxFull),
        .serialTxEmptyIn(txEmpty), .irq(irq));

    // Variant without the serial unit, sharing every input
    pif_flags #(.HAS_SERIAL(1'b0)) dutBasic (
        .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdataBasic),
        .pready(), .pslverr(), .syncSerialDone(ev[3]),
        .capcompEvent(ev[2]), .capcompMode(ccpMode), .timerTwoMatch(ev[1]),
        .timerOneOverflow(ev[0]), .serialRxFullIn(rxFull),
        .serialTxEmptyIn(txEmpty), .irq());

    // 40 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {20'h00000, a};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            mismatches++;
            end_sim();
        end
        rd = prdata;
        rdBasic = prdataBasic;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One-cycle event pulse; returns with the flag update landed
    task automatic pulse(input int b);
        @(posedge sys_clk);
        ev[b] <= 1'b1;
        @(posedge sys_clk);
        ev[b] <= 1'b0;
        #1;
    endtask

    task automatic t_events;
        logic [31:0] exp;
        exp = 32'h0;
        apb(0, `PIF_OFF_FLAGS, 0);
        chk("flags after reset", 32'h0, rd);
        apb(0, `PIF_OFF_MASK, 0);
        chk("mask after reset", 32'h0, rd);
        for (int b = 0; b < 4; b++) begin
            pulse(b);
            exp[b] = 1'b1;
            repeat (3) @(posedge sys_clk);
            apb(0, `PIF_OFF_FLAGS, 0);
            chk("flag set and held", exp, rd);
            chk("irq while masked", 32'h0, {31'h0, irq});
        end
        apb(1, `PIF_OFF_FLAGS, 0);
        apb(0, `PIF_OFF_FLAGS, 0);
        chk("flags cleared", 32'h0, rd);
    endtask

    // Capcomp flag only in capture and compare modes
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            ccpMode <= pif_pkg::pif_ccp_mode_t'(m[1:0]);
            pulse(2);
            apb(0, `PIF_OFF_FLAGS, 0);
            chk("capcomp flag", (m == 1 || m == 2) ? 32'h4 : 32'h0, rd);
            apb(1, `PIF_OFF_FLAGS, 0);
        end
    endtask

    task automatic t_irq;
        apb(0, `PIF_OFF_FLAGS, 0);
        chk("flags clear before enable", 32'h0, rd);
        apb(1, `PIF_OFF_MASK, 32'h01);
        pulse(1);
        chk("irq masked source", 32'h0, {31'h0, irq});
        pulse(0);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        apb(0, `PIF_OFF_IRQ, 0);
        chk("pending", 32'h1, rd);
        apb(1, `PIF_OFF_FLAGS, 0);
        #1;
        chk("irq after clear", 32'h0, {31'h0, irq});
    endtask

    // Set event and write of zero in the same cycle
    task automatic t_priority;
        pulse(0);
        pulse(1);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= 1'b1;
        paddr <= {20'h00000, `PIF_OFF_FLAGS};
        pwdata <= 32'h0;
        @(posedge sys_clk);
        penable <= 1'b1;
        ev[1] <= 1'b1;
        @(posedge sys_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        ev[1] <= 1'b0;
        apb(0, `PIF_OFF_FLAGS, 0);
        chk("set beats clear", 32'h2, rd);
        apb(1, `PIF_OFF_FLAGS, 0);
    endtask

    // Read-only buffer levels, unmapped access
    task automatic t_serial;
        @(posedge sys_clk);
        rxFull <= 1'b1;
        repeat (4) @(posedge sys_clk);
        apb(1, `PIF_OFF_FLAGS, 0);
        apb(0, `PIF_OFF_FLAGS, 0);
        chk("rx full flag", 32'h20, rd);
        chk("basic rx bit", 32'h0, rdBasic);
        rxFull <= 1'b0;
        txEmpty <= 1'b1;
        repeat (4) @(posedge sys_clk);
        apb(1, `PIF_OFF_FLAGS, 32'h20);
        apb(0, `PIF_OFF_FLAGS, 0);
        chk("tx empty flag", 32'h10, rd);
        chk("basic tx bit", 32'h0, rdBasic);
        txEmpty <= 1'b0;
        apb(1, 12'h020, 32'hFF);
        chk("unmapped write error", 32'h1, {31'h0, err});
        apb(0, 12'h020, 0);
        chk("unmapped read", 32'h0, rd);
    endtask

    initial begin
        rstn = 1'b0;
        {psel, penable, pwrite, rxFull, txEmpty} = 5'h00;
        paddr = 32'h0;
        pwdata = 32'h0;
        ev = 4'h0;
        ccpMode = pif_pkg::PIF_CCP_CAPTURE;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        t_events();
        t_modes();
        t_irq();
        t_priority();
        t_serial();
        end_sim();
    end
endmodule
